// >>> tdw_pkg.sv
// Purpose: Shared constants for the telemetry decoder with learn and watchdog
// Assumes: 125 MHz system clock, 32-bit classic Wishbone register bus
// Notes: Times are kept in printed units; cycle counts derive from them
package tdw_pkg;
   localparam longint unsigned CLK_HZ = 64'd125_000_000;

   // Printed times
   localparam longint unsigned FILT_MS = 64'd5;
   localparam longint unsigned PERIOD_S = 64'd5;
   localparam longint unsigned WDOG_S = 64'd20;
   localparam longint unsigned HOLD_S = 64'd10;
   // Chosen indicator timings
   localparam longint unsigned BLINK_MS = 64'd250;
   localparam longint unsigned LEARN_FLASH_MS = 64'd2000;

   // Cycle counts; the filter time rounds up, the indicator timings round down
   localparam longint unsigned FILT_CYC = (FILT_MS * CLK_HZ + 999) / 1000;
   localparam longint unsigned PERIOD_CYC = PERIOD_S * CLK_HZ;
   localparam longint unsigned WDOG_CYC = WDOG_S * CLK_HZ;
   localparam longint unsigned HOLD_CYC = HOLD_S * CLK_HZ;
   localparam longint unsigned BLINK_CYC = BLINK_MS * CLK_HZ / 1000;
   localparam longint unsigned LEARN_FLASH_CYC = LEARN_FLASH_MS * CLK_HZ / 1000;

   localparam int N_IN = 8;
   localparam int N_OUT = 16;
   localparam int ID_W = 16;
   localparam int N_TX = 48;
   localparam int SLOT_W = 6;
   localparam int WDOG_CH = 15;
   localparam int HIGH_BANK_BASE = 8;
   localparam int HIGH_BANK_N = 7;
   localparam logic [3:0] CFG_FLASH_EDGES = 4'ha;
   localparam logic [1:0] BOOT_CYCLES = 2'h3;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
   localparam logic [7:0] REG_TX_LAST = 8'h10;

   // Control fields
   localparam int CTRL_RX_EN = 0;
   localparam int CTRL_LEARN = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;

   // Status fields
   localparam int ST_CONFIGURED = 16;
   localparam int ST_LEARN_MODE = 17;
   localparam int ST_LEARN_READY = 18;
   localparam int ST_COUNT_LSB = 24;

   // Interrupt bits
   localparam int IRQ_W = 5;
   localparam int IRQ_PKT = 0;
   localparam int IRQ_LEARNED = 1;
   localparam int IRQ_ERASED = 2;
   localparam int IRQ_WDOG_LOST = 3;
   localparam int IRQ_TX_SENT = 4;

   localparam logic [15:0] LED_ALT = 16'h5555;

   typedef enum logic [2:0] {
      RX_BOOT, RX_UNCFG, RX_CFG_FLASH, RX_RUN,
      RX_LEARN_FLASH, RX_LEARN_READY, RX_HOLD, RX_HOLD_DONE
   } tdw_rx_st_t;
endpackage

// >>> tdw_tx_enc.sv
// Purpose: Transmitter encoder: filters contacts and issues input packets
// Assumes: Contact and link pins are asynchronous and synchronised here
// Notes: Periodic sends restart their interval after every send
`timescale 1ns/1ps
`default_nettype none
module tdw_tx_enc
   import tdw_pkg::*;
#(
   parameter logic [31:0] FILT_CYCLES = 32'(FILT_CYC),
   parameter logic [31:0] PERIOD_CYCLES = 32'(PERIOD_CYC)
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [N_IN-1:0] contact_i,
   input wire logic [N_IN-1:0] input_enable_i,
   input wire logic bank_select_i,
   input wire logic periodic_send_header_i,
   output logic tx_valid_o,
   output logic [N_IN-1:0] tx_data_o,
   output logic [N_IN-1:0] tx_mask_o,
   output logic tx_bank_o,
   output logic tx_periodic_o
);
   logic [N_IN+2:0] meta_q, sync_q;
   logic [N_IN-1:0] filt_q;
   logic [N_IN-1:0] change;
   logic [31:0] period_cnt_q;
   logic period_due;
   logic [N_IN-1:0] en_meta_q, en_sync_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
         en_meta_q <= '0;
         en_sync_q <= '0;
      end else begin
         meta_q <= {periodic_send_header_i, bank_select_i, 1'b0, contact_i};
         sync_q <= meta_q;
         // Enable links are pins too; read only after two flops
         en_meta_q <= input_enable_i;
         en_sync_q <= en_meta_q;
      end
   end

   // Per-input glitch filter
   genvar g;
   generate
      for (g = 0; g < N_IN; g++) begin : g_filt
         logic [31:0] cnt_q;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               cnt_q <= '0;
               filt_q[g] <= 1'b0;
            end else if (sync_q[g] == filt_q[g]) begin
               cnt_q <= '0;
            end else if (cnt_q >= FILT_CYCLES - 32'h1) begin
               cnt_q <= '0;
               filt_q[g] <= sync_q[g];
            end else begin
               cnt_q <= cnt_q + 32'h1;
            end
         end
         assign change[g] = (sync_q[g] != filt_q[g]) && en_sync_q[g]
                            && (cnt_q >= FILT_CYCLES - 32'h1);
      end
   endgenerate

   assign period_due = sync_q[N_IN+2] && (period_cnt_q >= PERIOD_CYCLES - 32'h1);

   always_ff @(posedge clk_i) begin
      // Restart on the send itself, else the due flag stays high on every later cycle
      if (rst_i || !sync_q[N_IN+2] || period_due || (|change)) begin
         period_cnt_q <= '0;
      end else begin
         period_cnt_q <= period_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_valid_o <= 1'b0;
         tx_data_o <= '0;
         tx_mask_o <= '0;
         tx_bank_o <= 1'b0;
         tx_periodic_o <= 1'b0;
      end else begin
         tx_valid_o <= (|change) || period_due;
         tx_data_o <= (filt_q ^ change) & en_sync_q;
         tx_mask_o <= en_sync_q;
         tx_bank_o <= sync_q[N_IN+1];
         tx_periodic_o <= sync_q[N_IN+2];
      end
   end
endmodule
`default_nettype wire

// >>> tdw_top.sv
// Purpose: Telemetry receiver decoder with learning, indicators, watchdog
// Assumes: Radio packets arrive already decoded on clk_i, one-cycle strobe
// Notes: Learned identities live in volatile storage; cleared by reset
`timescale 1ns/1ps
`default_nettype none
module tdw_top
   import tdw_pkg::*;
#(
   parameter logic [31:0] FILT_CYCLES = 32'(FILT_CYC),
   parameter logic [31:0] PERIOD_CYCLES = 32'(PERIOD_CYC),
   parameter logic [31:0] WDOG_CYCLES = 32'(WDOG_CYC),
   parameter logic [31:0] HOLD_CYCLES = 32'(HOLD_CYC),
   parameter logic [31:0] BLINK_CYCLES = 32'(BLINK_CYC),
   parameter logic [31:0] LEARN_FLASH_CYCLES = 32'(LEARN_FLASH_CYC)
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   // Local transmitter
   input wire logic [N_IN-1:0] contact_i,
   input wire logic [N_IN-1:0] input_enable_i,
   input wire logic bank_select_i,
   input wire logic periodic_send_header_i,
   output logic tx_valid_o,
   output logic [N_IN-1:0] tx_data_o,
   output logic [N_IN-1:0] tx_mask_o,
   output logic tx_bank_o,
   output logic tx_periodic_o,
   // Decoded radio packets
   input wire logic rx_valid_i,
   input wire logic rx_compat_i,
   input wire logic [ID_W-1:0] rx_id_i,
   input wire logic [N_IN-1:0] rx_data_i,
   input wire logic [N_IN-1:0] rx_mask_i,
   input wire logic rx_bank_i,
   input wire logic rx_periodic_i,
   // Front panel
   input wire logic learn_button_i,
   input wire logic cfg_stored_i,
   input wire logic [N_OUT-1:0] general_option_links_i,
   output logic cfg_stored_o,
   output logic [N_OUT-1:0] out_o,
   output logic [N_OUT-1:0] out_led_o,
   output logic config_indicator_o,
   output logic learn_indicator_o
);
   tdw_rx_st_t st_q;
   logic [1:0] ctrl_q;
   logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
   logic [N_OUT-1:0] out_q;
   logic [ID_W-1:0] id_mem_q [N_TX];
   logic [N_TX-1:0] id_vld_q;
   logic [SLOT_W:0] count_q;
   logic [31:0] tmr_q, blink_cnt_q, wdog_cnt_q;
   logic blink_q, blink_edge;
   logic [3:0] flash_q;
   logic [1:0] boot_q;
   logic [1:0] btn_meta_q, btn_sync_q;
   logic btn, btn_prev_q;
   logic pkt_ok, known, learn_sw, erase;
   logic wb_hit, wb_wr;
   logic [31:0] rd_d;

   // Option links deliberately unread in this mode
   tdw_tx_enc #(
      .FILT_CYCLES(FILT_CYCLES),
      .PERIOD_CYCLES(PERIOD_CYCLES)
   ) u_tx (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .contact_i(contact_i),
      .input_enable_i(input_enable_i),
      .bank_select_i(bank_select_i),
      .periodic_send_header_i(periodic_send_header_i),
      .tx_valid_o(tx_valid_o),
      .tx_data_o(tx_data_o),
      .tx_mask_o(tx_mask_o),
      .tx_bank_o(tx_bank_o),
      .tx_periodic_o(tx_periodic_o)
   );

   function automatic logic id_match(input logic [ID_W-1:0] id,
                                     input logic [N_TX-1:0] vld,
                                     input logic [ID_W-1:0] mem [N_TX]);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < N_TX; i++) begin
         if (vld[i] && mem[i] == id) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // Panel inputs are asynchronous
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         btn_meta_q <= '0;
         btn_sync_q <= '0;
         btn_prev_q <= 1'b0;
      end else begin
         btn_meta_q <= {cfg_stored_i, learn_button_i};
         btn_sync_q <= btn_meta_q;
         btn_prev_q <= btn_sync_q[0];
      end
   end
   assign btn = btn_sync_q[0];

   assign pkt_ok = rx_valid_i && rx_compat_i && ctrl_q[CTRL_RX_EN];
   assign known = id_match(rx_id_i, id_vld_q, id_mem_q);
   assign learn_sw = wb_wr && wb_adr_i == REG_CTRL && wb_sel_i[0]
                     && wb_dat_i[CTRL_LEARN];
   assign erase = st_q == RX_HOLD_DONE && !btn;

   // Free-running indicator blink
   assign blink_edge = blink_cnt_q >= BLINK_CYCLES - 32'h1;
   always_ff @(posedge clk_i) begin
      if (rst_i || blink_edge) begin
         blink_cnt_q <= '0;
      end else begin
         blink_cnt_q <= blink_cnt_q + 32'h1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         blink_q <= 1'b0;
      end else if (blink_edge) begin
         blink_q <= ~blink_q;
      end
   end

   // Receiver state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= RX_BOOT;
         tmr_q <= '0;
         flash_q <= '0;
         boot_q <= '0;
      end else begin
         tmr_q <= tmr_q + 32'h1;
         if (blink_edge) begin
            flash_q <= flash_q + 4'h1;
         end
         unique case (st_q)
            RX_BOOT: begin
               boot_q <= boot_q + 2'h1;
               flash_q <= '0;
               if (boot_q == BOOT_CYCLES) begin
                  st_q <= btn_sync_q[1] ? RX_CFG_FLASH : RX_UNCFG;
               end
            end
            RX_UNCFG: begin
               flash_q <= '0;
               if (btn && !btn_prev_q) begin
                  st_q <= RX_HOLD;
                  tmr_q <= '0;
               end else if (pkt_ok) begin
                  st_q <= RX_CFG_FLASH;
               end
            end
            RX_CFG_FLASH: begin
               // Leave on the last dark edge, so no sixth pulse
               if (blink_edge && flash_q == CFG_FLASH_EDGES - 4'h1) begin
                  st_q <= RX_RUN;
               end
            end
            RX_RUN: begin
               if (btn && !btn_prev_q) begin
                  st_q <= RX_HOLD;
                  tmr_q <= '0;
               end else if (learn_sw) begin
                  st_q <= RX_LEARN_FLASH;
                  tmr_q <= '0;
               end
            end
            RX_LEARN_FLASH: begin
               if (tmr_q >= LEARN_FLASH_CYCLES - 32'h1) begin
                  st_q <= RX_LEARN_READY;
               end
            end
            RX_LEARN_READY: begin
               if (pkt_ok) begin
                  st_q <= RX_RUN;
               end
            end
            RX_HOLD: begin
               if (!btn) begin
                  st_q <= cfg_stored_o ? RX_LEARN_FLASH : RX_UNCFG;
                  tmr_q <= '0;
               end else if (tmr_q >= HOLD_CYCLES - 32'h1) begin
                  st_q <= RX_HOLD_DONE;
               end
            end
            RX_HOLD_DONE: begin
               if (!btn) begin
                  st_q <= RX_UNCFG;
               end
            end
         endcase
      end
   end

   // Configured flag, mirrored out for retention
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_stored_o <= 1'b0;
      end else if (erase) begin
         cfg_stored_o <= 1'b0;
      end else if ((st_q == RX_UNCFG && pkt_ok && !(btn && !btn_prev_q))
                   || (st_q == RX_BOOT && boot_q == BOOT_CYCLES
                       && btn_sync_q[1])) begin
         cfg_stored_o <= 1'b1;
      end
   end

   // Transmitter memory
   always_ff @(posedge clk_i) begin
      if (rst_i || erase) begin
         id_vld_q <= '0;
         count_q <= '0;
      end else if (st_q == RX_LEARN_READY && pkt_ok && !known
                   && count_q < (SLOT_W+1)'(N_TX)) begin
         id_vld_q[count_q[SLOT_W-1:0]] <= 1'b1;
         id_mem_q[count_q[SLOT_W-1:0]] <= rx_id_i;
         count_q <= count_q + (SLOT_W+1)'(1);
      end
   end

   // Output channels
   always_ff @(posedge clk_i) begin
      if (rst_i || erase) begin
         out_q <= '0;
         wdog_cnt_q <= '0;
      end else begin
         if (wdog_cnt_q != '0) begin
            wdog_cnt_q <= wdog_cnt_q - 32'h1;
         end else begin
            out_q[WDOG_CH] <= 1'b0;
         end
         if (pkt_ok && known && st_q != RX_UNCFG) begin
            for (int i = 0; i < N_IN; i++) begin
               if (rx_mask_i[i] && !rx_bank_i) begin
                  out_q[i] <= rx_data_i[i];
               end
               if (rx_mask_i[i] && rx_bank_i && i < HIGH_BANK_N) begin
                  out_q[HIGH_BANK_BASE + i] <= rx_data_i[i];
               end
            end
            if (rx_periodic_i) begin
               out_q[WDOG_CH] <= 1'b1;
               wdog_cnt_q <= WDOG_CYCLES;
            end
         end
      end
   end

   // Pins and indicators
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_o <= '0;
         out_led_o <= '0;
         config_indicator_o <= 1'b0;
         learn_indicator_o <= 1'b0;
      end else begin
         out_o <= out_q;
         out_led_o <= st_q == RX_UNCFG ?
                      (blink_q ? LED_ALT : ~LED_ALT) : out_q;
         config_indicator_o <= st_q == RX_CFG_FLASH && !flash_q[0];
         learn_indicator_o <= (st_q == RX_LEARN_FLASH && blink_q)
                              || st_q == RX_LEARN_READY || st_q == RX_HOLD;
      end
   end

   // Wishbone slave, one wait state
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr = wb_hit && wb_we_i;

   always_comb begin
      rd_d = '0;
      unique case (wb_adr_i)
         REG_CTRL: rd_d[1:0] = {1'b0, ctrl_q[CTRL_RX_EN]};
         REG_STATUS: begin
            rd_d[N_OUT-1:0] = out_q;
            rd_d[ST_CONFIGURED] = cfg_stored_o;
            rd_d[ST_LEARN_MODE] = st_q == RX_LEARN_FLASH
                                  || st_q == RX_LEARN_READY;
            rd_d[ST_LEARN_READY] = st_q == RX_LEARN_READY;
            rd_d[ST_COUNT_LSB +: SLOT_W+1] = count_q;
         end
         REG_IRQ_STAT: rd_d[IRQ_W-1:0] = irq_stat_q;
         REG_IRQ_MASK: rd_d[IRQ_W-1:0] = irq_mask_q;
         REG_TX_LAST: rd_d[2*N_IN-1:0] = {tx_mask_o, tx_data_o};
         default: rd_d = '0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_hit;
         wb_dat_o <= wb_hit ? rd_d : '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CTRL_RESET;
         irq_mask_q <= '0;
      end else if (wb_wr && wb_sel_i[0]) begin
         if (wb_adr_i == REG_CTRL) begin
            ctrl_q <= {1'b0, wb_dat_i[CTRL_RX_EN]};
         end
         if (wb_adr_i == REG_IRQ_MASK) begin
            irq_mask_q <= wb_dat_i[IRQ_W-1:0];
         end
      end
   end

   // Sticky events; a set beats a same-cycle clear
   always_comb begin
      irq_set = '0;
      irq_set[IRQ_PKT] = pkt_ok && known && st_q != RX_UNCFG;
      irq_set[IRQ_LEARNED] = st_q == RX_LEARN_READY && pkt_ok && !known;
      irq_set[IRQ_ERASED] = erase;
      irq_set[IRQ_WDOG_LOST] = out_q[WDOG_CH] && wdog_cnt_q == '0;
      irq_set[IRQ_TX_SENT] = tx_valid_o;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= '0;
         irq_o <= 1'b0;
      end else begin
         if (wb_wr && wb_sel_i[0] && wb_adr_i == REG_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~wb_dat_i[IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
         irq_o <= |(irq_stat_q & irq_mask_q);
      end
   end
endmodule
`default_nettype wire

// >>> tdw_top_properties.sv
// Purpose: Port-level checks for the telemetry receiver
// Assumes: One clock, synchronous active-high reset
// Notes: Counters stand in for long waits
`timescale 1ns/1ps
`default_nettype none
module tdw_top_props
   import tdw_pkg::*;
#(
   parameter logic [31:0] WDOG_CYCLES = 32'h1f4,
   parameter logic [31:0] HOLD_CYCLES = 32'h12c
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic tx_valid_o,
   input wire logic [N_IN-1:0] tx_data_o,
   input wire logic [N_IN-1:0] tx_mask_o,
   input wire logic rx_valid_i,
   input wire logic rx_periodic_i,
   input wire logic learn_button_i,
   input wire logic [N_OUT-1:0] out_o,
   input wire logic learn_indicator_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [31:0] quiet_q;
   logic [31:0] held_q;
   // Saturate so a long idle never wraps back to zero
   always_ff @(posedge clk_i) begin
      if (rst_i || (rx_valid_i && rx_periodic_i)) quiet_q <= '0;
      else if (quiet_q != 32'hffffffff) quiet_q <= quiet_q + 32'h1;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || !learn_button_i) held_q <= '0;
      else if (held_q != 32'hffffffff) held_q <= held_q + 32'h1;
   end
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_taken: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("request not answered");
   chk_ack_cause: assert property ($rose(wb_ack_o) |->
      $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   chk_tx_masked: assert property (tx_valid_o |->
      (tx_data_o & ~tx_mask_o) == 8'h0) else $error("disabled input sent");
   chk_wdog_set: assert property ($rose(out_o[WDOG_CH]) |->
      $past(rx_valid_i && rx_periodic_i, 2)) else $error("out16 no cause");
   chk_wdog_drop: assert property (quiet_q == WDOG_CYCLES + 32'h4 |->
      !out_o[WDOG_CH]) else $error("out16 held after silence");
   chk_learn_on: assert property (held_q == 32'h8 |->
      learn_indicator_o) else $error("learn led dark while held");
   chk_learn_off: assert property (held_q == HOLD_CYCLES + 32'h10 |->
      !learn_indicator_o) else $error("learn led lit after hold");
endmodule
bind tdw_top tdw_top_props #(.WDOG_CYCLES(WDOG_CYCLES),
   .HOLD_CYCLES(HOLD_CYCLES)) u_props (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_dat_o, .wb_ack_o, .tx_valid_o, .tx_data_o, .tx_mask_o,
   .rx_valid_i, .rx_periodic_i, .learn_button_i, .out_o,
   .learn_indicator_o);
`default_nettype wire

// >>> tdw_radio_model.sv
// Purpose: Remote transmitter seen through the radio decoder
// Assumes: Packets are one-cycle strobes on the system clock
// Notes: Lines are scrambled outside the strobe
`timescale 1ns/1ps
`default_nettype none
module tdw_radio_model
   import tdw_pkg::*;
(
   input wire logic clk_i,
   output logic rx_valid_o,
   output logic rx_compat_o,
   output logic [ID_W-1:0] rx_id_o,
   output logic [N_IN-1:0] rx_data_o,
   output logic [N_IN-1:0] rx_mask_o,
   output logic rx_bank_o,
   output logic rx_periodic_o
);
   initial begin
      rx_valid_o = 1'h0;
      rx_compat_o = 1'h1;
      rx_id_o = '0;
      rx_data_o = '0;
      rx_mask_o = '0;
      rx_bank_o = 1'h0;
      rx_periodic_o = 1'h0;
   end
   task automatic send(input logic [ID_W-1:0] id, input logic [N_IN-1:0] d,
      input logic [N_IN-1:0] m, input logic b, input logic p);
      @(posedge clk_i);
      rx_valid_o <= 1'h1;
      rx_id_o <= id;
      rx_data_o <= d;
      rx_mask_o <= m;
      rx_bank_o <= b;
      rx_periodic_o <= p;
      @(posedge clk_i);
      // Inverted so stale values are never mistaken for a packet
      rx_valid_o <= 1'h0;
      rx_id_o <= ~id;
      rx_data_o <= ~d;
      rx_mask_o <= ~m;
      rx_bank_o <= ~b;
      rx_periodic_o <= ~p;
   endtask
endmodule
`default_nettype wire

// >>> tdw_top_tb.sv
// Purpose: Self-checking bench for the telemetry receiver
// Assumes: Shortened counts set at the instance
// Notes: Reference keeps learned ids and expected outputs
`timescale 1ns/1ps
`default_nettype none
module tdw_top_tb
   import tdw_pkg::*;
;
   localparam logic [31:0] WD = 32'h1f4;
   localparam logic [31:0] HLD = 32'h12c;
   localparam logic [15:0] A = 16'h1234;
   logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
   logic wb_we_i = 1'h0, bank_select_i = 1'h0, periodic_send_header_i = 1'h0;
   logic learn_button_i = 1'h0, cfg_stored_i = 1'h0, cir = 1'h0;
   logic [7:0] wb_adr_i = '0, contact_i = '0, input_enable_i = 8'h0f;
   logic [3:0] wb_sel_i = '0;
   logic [31:0] wb_dat_i = '0, wb_dat_o, q, r, r2;
   logic wb_ack_o, irq_o, tx_valid_o, tx_bank_o, tx_periodic_o, rx_valid_i;
   logic cfg_stored_o, config_indicator_o, learn_indicator_o, rx_compat_i;
   logic rx_bank_i, rx_periodic_i;
   logic [7:0] tx_data_o, tx_mask_o, rx_data_i, rx_mask_i, txd;
   logic [15:0] rx_id_i, out_o, out_led_o, general_option_links_i = '0;
   logic [15:0] eo = '0;
   logic [15:0] ids[$];
   int mismatches = 0, compares = 0, cyc = 0, txn = 0, rises = 0, seed;
   tdw_top #(.FILT_CYCLES(32'h4), .PERIOD_CYCLES(32'hc8), .WDOG_CYCLES(WD),
      .HOLD_CYCLES(HLD), .BLINK_CYCLES(32'h8), .LEARN_FLASH_CYCLES(32'h28))
   dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .contact_i, .input_enable_i,
      .bank_select_i, .periodic_send_header_i, .tx_valid_o, .tx_data_o,
      .tx_mask_o, .tx_bank_o, .tx_periodic_o, .rx_valid_i, .rx_compat_i,
      .rx_id_i, .rx_data_i, .rx_mask_i, .rx_bank_i, .rx_periodic_i,
      .learn_button_i, .cfg_stored_i, .general_option_links_i, .cfg_stored_o,
      .out_o, .out_led_o, .config_indicator_o, .learn_indicator_o);
   tdw_radio_model rdo (.clk_i, .rx_valid_o(rx_valid_i),
      .rx_compat_o(rx_compat_i), .rx_id_o(rx_id_i), .rx_data_o(rx_data_i),
      .rx_mask_o(rx_mask_i), .rx_bank_o(rx_bank_i),
      .rx_periodic_o(rx_periodic_i));
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      cir <= config_indicator_o;
      if (config_indicator_o === 1'h1 && cir === 1'h0) rises++;
      if (tx_valid_o === 1'h1) begin
         txn++;
         txd = tx_data_o;
      end
      if (cyc > 20000) begin
         mismatches++;
         print_verdict;
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task print_verdict;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task tk(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task do_reset;
      rst_i <= 1'h1;
      tk(12);
      rst_i <= 1'h0;
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 40);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      if (n >= 40) chk(32'h0, 32'h1);
      @(posedge clk_i);
   endtask
   task ledw(input logic [15:0] v);
      int n;
      n = 0;
      while (out_led_o !== v && n < 60) begin
         @(posedge clk_i);
         n++;
      end
      chk(out_led_o, v);
   endtask
   // Only learned senders move the expected outputs
   task pkt(input logic [15:0] id, input logic [7:0] d, input logic [7:0] m,
      input logic b, input logic p);
      rdo.send(id, d, m, b, p);
      if (id inside {ids}) begin
         for (int i = 0; i < 8; i++) begin
            if (m[i] && !(b && i == 7)) eo[i + 8 * b] = d[i];
         end
         if (p) eo[15] = 1'h1;
      end
      tk(4);
   endtask
   initial begin
      seed = 32'h9af2;
      do_reset;
      wb(1'h0, REG_CTRL, '0);
      chk(q, 32'h1);
      wb(1'h1, 8'h40, 32'hffffffff);
      wb(1'h0, 8'h40, '0);
      chk(q, 32'h0);
      ledw(LED_ALT);
      ledw(~LED_ALT);
      rises = 0;
      pkt(16'h0001, 8'hff, 8'hff, 1'h0, 1'h0);
      chk(cfg_stored_o, 32'h1);
      tk(150);
      chk(rises, 5);
      chk(out_o, eo);
      cfg_stored_i <= 1'h1;
      rises = 0;
      do_reset;
      tk(150);
      chk(rises, 5);
      learn_button_i <= 1'h1;
      tk(6);
      chk(learn_indicator_o, 32'h1);
      learn_button_i <= 1'h0;
      q = '0;
      for (int k = 0; k < 40 && q[ST_LEARN_READY] !== 1'h1; k++)
         wb(1'h0, REG_STATUS, '0);
      chk(learn_indicator_o, 32'h1);
      pkt(A, 8'h00, 8'h00, 1'h0, 1'h0);
      ids.push_back(A);
      chk(learn_indicator_o, 32'h0);
      wb(1'h0, REG_STATUS, '0);
      chk(q[30:24], 32'h1);
      wb(1'h1, REG_CTRL, 32'h3);
      q = '0;
      for (int k = 0; k < 40 && q[ST_LEARN_READY] !== 1'h1; k++)
         wb(1'h0, REG_STATUS, '0);
      pkt(16'h0567, 8'h00, 8'h00, 1'h0, 1'h0);
      ids.push_back(16'h0567);
      wb(1'h0, REG_STATUS, '0);
      chk(q[30:24], 32'h2);
      repeat (8) begin
         r = $random(seed);
         r2 = $random(seed);
         // Option links scrambled under live traffic
         general_option_links_i <= r[31:16];
         pkt(r[0] ? A : {1'h1, r[15:1]}, r2[7:0], r2[15:8], r2[16], 1'h0);
         chk(out_o, eo);
         chk(out_led_o, eo);
      end
      wb(1'h1, REG_IRQ_STAT, 32'hffffffff);
      wb(1'h1, REG_IRQ_MASK, 32'h1);
      chk(irq_o, 32'h0);
      pkt(A, 8'h00, 8'h00, 1'h0, 1'h0);
      chk(irq_o, 32'h1);
      wb(1'h1, REG_IRQ_STAT, 32'h1);
      tk(2);
      chk(irq_o, 32'h0);
      wb(1'h1, REG_IRQ_MASK, '0);
      pkt(A, 8'h00, 8'h00, 1'h0, 1'h1);
      chk(out_o[15], 32'h1);
      tk(300);
      pkt(A, 8'h00, 8'h00, 1'h0, 1'h1);
      tk(WD - 14);
      chk(out_o[15], 32'h1);
      tk(20);
      chk(out_o[15], 32'h0);
      bank_select_i <= 1'h1;
      contact_i <= 8'h80;
      txn = 0;
      tk(30);
      chk(txn, 0);
      contact_i <= 8'h81;
      tk(20);
      chk(txd, 32'h01);
      chk(tx_bank_o, 32'h1);
      contact_i <= 8'h83;
      tk(8);
      contact_i <= 8'h81;
      tk(20);
      chk(txn, 3);
      chk(tx_mask_o, 32'h0f);
      periodic_send_header_i <= 1'h1;
      txn = 0;
      tk(450);
      chk(txn, 2);
      periodic_send_header_i <= 1'h0;
      tk(10);
      txn = 0;
      tk(450);
      chk(txn, 0);
      learn_button_i <= 1'h1;
      tk(10);
      chk(learn_indicator_o, 32'h1);
      tk(HLD + 10);
      chk(learn_indicator_o, 32'h0);
      learn_button_i <= 1'h0;
      tk(10);
      chk(cfg_stored_o, 32'h0);
      ids.delete();
      eo = '0;
      ledw(LED_ALT);
      pkt(A, 8'hff, 8'hff, 1'h0, 1'h0);
      chk(out_o, eo);
      tk(150);
      pkt(A, 8'hff, 8'hff, 1'h0, 1'h0);
      chk(out_o, eo);
      wb(1'h0, REG_STATUS, '0);
      chk(q[30:24], 32'h0);
      print_verdict;
   end
endmodule
`default_nettype wire
